// file: design/tmx_timer.sv
/*
 * External-count timer with one 8-bit scaler shared with the watchdog.
 * Assumes a single 25 MHz clk, a strobe register port, and a pad that
 * resolves the open-drain pin from pin_oe.
 */
`timescale 1ns/1ps
`default_nettype none
module tmx_timer #(
	parameter int WDT_BASE_CYCLES = 8192
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Register port
	input wire logic [tmx_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [tmx_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [tmx_pkg::DATA_W-1:0] reg_rdata,
	// Port A pin 4, open drain
	input wire logic port_a_pin4_in,
	output logic port_a_pin4_out,
	output logic port_a_pin4_oe,
	// Events
	output logic timer_irq,
	output logic watchdog_timeout
);
	import tmx_pkg::*;

	tmx_pin_if pin_if ();
	tmx_phase_t phase_q;
	logic [7:0] count_register_q;
	logic [7:0] scaler_q;
	logic [2:0] scaler_ratio_field_q;
	logic scaler_assign_select_q;
	logic overflow_flag_q;
	logic overflow_irq_enable_q;
	logic global_irq_enable_q;
	logic port_latch_q;
	logic port_dir_q;
	logic sampled_q;
	logic [31:0] wdt_base_q;
	logic [DATA_W-1:0] rdata_q;
	logic irq_q;
	logic wdt_timeout_q;
	logic pin_oe_q;
	logic ext_count_input;
	logic on_timer;
	logic scaled_out;
	logic sample_now;
	logic count_inc;
	logic count_wr;
	logic int_wr;
	logic watchdog_clear_instr;
	logic wdt_tick;
	logic scaler_step;
	logic [7:0] tap_mask;
	logic scaler_full;

	assign pin_if.raw = port_a_pin4_in;
	tmx_pin_sync u_sync (
		.clk(clk),
		.rst(rst),
		.pin(pin_if.snk)
	);
	assign ext_count_input = pin_if.level;

	assign on_timer = !scaler_assign_select_q;
	assign count_wr = reg_wr && (reg_addr == REG_COUNT);
	assign int_wr = reg_wr && (reg_addr == REG_INTCTL);
	assign watchdog_clear_instr = reg_wr && (reg_addr == REG_WDCLR);
	assign tap_mask = (TAP_BASE << scaler_ratio_field_q) - SCALER_ONE;
	assign scaler_full = (scaler_q | ~tap_mask) == COUNT_MAX;
	assign wdt_tick = (wdt_base_q == 32'(WDT_BASE_CYCLES - 1));
	assign scaler_step = on_timer ? pin_if.rise : wdt_tick;
	// Tapped scaler bit when scaled, raw clean level otherwise
	assign scaled_out = on_timer ? scaler_q[scaler_ratio_field_q] : ext_count_input;
	assign sample_now = (phase_q == PH_TWO) || (phase_q == PH_FOUR);
	assign count_inc = sample_now && scaled_out && !sampled_q;

	// Instruction phase sequencer
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			phase_q <= PH_ONE;
		end else begin
			unique case (phase_q)
				PH_ONE: phase_q <= PH_TWO;
				PH_TWO: phase_q <= PH_THREE;
				PH_THREE: phase_q <= PH_FOUR;
				PH_FOUR: phase_q <= PH_ONE;
			endcase
		end
	end

	// Edge sampler
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sampled_q <= 1'b0;
		end else if (sample_now) begin
			sampled_q <= scaled_out;
		end
	end

	// Shared scaler, no register address; its owner's clear write (REG_COUNT or REG_WDCLR) zeroes it
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			scaler_q <= '0;
		end else if (count_wr && on_timer) begin
			scaler_q <= '0;
		end else if (watchdog_clear_instr && !on_timer) begin
			scaler_q <= '0;
		end else if (scaler_step) begin
			scaler_q <= scaler_q + SCALER_ONE;
		end
	end

	// Option bits
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			scaler_assign_select_q <= OPTION_RST[OPT_ASSIGN_BIT];
			scaler_ratio_field_q <= OPTION_RST[OPT_RATIO_LSB +: 3];
		end else if (reg_wr && reg_addr == REG_OPTION) begin
			scaler_assign_select_q <= reg_wdata[OPT_ASSIGN_BIT];
			scaler_ratio_field_q <= reg_wdata[OPT_RATIO_LSB +: 3];
		end
	end

	// Count register
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			count_register_q <= '0;
		end else if (count_wr) begin
			count_register_q <= reg_wdata;
		end else if (count_inc) begin
			count_register_q <= count_register_q + SCALER_ONE;
		end
	end

	// Interrupt control, overflow set wins over a clearing write
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			overflow_flag_q <= 1'b0;
			overflow_irq_enable_q <= 1'b0;
			global_irq_enable_q <= 1'b0;
		end else begin
			if (int_wr) begin
				overflow_irq_enable_q <= reg_wdata[INT_EN_BIT];
				global_irq_enable_q <= reg_wdata[INT_GIE_BIT];
			end
			if (count_inc && !count_wr && count_register_q == COUNT_MAX) begin
				overflow_flag_q <= 1'b1;
			end else if (int_wr) begin
				overflow_flag_q <= reg_wdata[INT_FLAG_BIT];
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= overflow_flag_q && overflow_irq_enable_q && global_irq_enable_q;
		end
	end

	// Watchdog base and timeout
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wdt_base_q <= '0;
			wdt_timeout_q <= 1'b0;
		end else begin
			if (watchdog_clear_instr || wdt_tick) begin
				wdt_base_q <= '0;
			end else begin
				wdt_base_q <= wdt_base_q + 32'h0000_0001;
			end
			wdt_timeout_q <= wdt_tick && !watchdog_clear_instr && (on_timer || scaler_full);
		end
	end

	// Open-drain pin, pulls low only
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			port_latch_q <= PORT_LATCH_RST;
			port_dir_q <= DIR_RST;
			pin_oe_q <= 1'b0;
		end else begin
			if (reg_wr && reg_addr == REG_PORT) begin
				port_latch_q <= reg_wdata[PIN_BIT];
			end
			if (reg_wr && reg_addr == REG_DIR) begin
				port_dir_q <= reg_wdata[PIN_BIT];
			end
			pin_oe_q <= !port_dir_q && !port_latch_q;
		end
	end

	// Read port, one cycle later; scaler has no address
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rdata_q <= READ_ZERO;
		end else if (reg_rd) begin
			rdata_q <= READ_ZERO;
			unique case (reg_addr)
				REG_COUNT: rdata_q <= count_register_q;
				REG_OPTION: begin
					rdata_q[OPT_ASSIGN_BIT] <= scaler_assign_select_q;
					rdata_q[OPT_RATIO_LSB +: 3] <= scaler_ratio_field_q;
				end
				REG_INTCTL: begin
					rdata_q[INT_GIE_BIT] <= global_irq_enable_q;
					rdata_q[INT_EN_BIT] <= overflow_irq_enable_q;
					rdata_q[INT_FLAG_BIT] <= overflow_flag_q;
				end
				REG_PORT: rdata_q[PIN_BIT] <= ext_count_input;
				REG_DIR: rdata_q[PIN_BIT] <= port_dir_q;
				default: rdata_q <= READ_ZERO;
			endcase
		end else begin
			rdata_q <= READ_ZERO;
		end
	end

	assign reg_rdata = rdata_q;
	assign timer_irq = irq_q;
	assign watchdog_timeout = wdt_timeout_q;
	assign port_a_pin4_oe = pin_oe_q;
	assign port_a_pin4_out = 1'b0;

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	phase_walk_a: assert property (phase_q == PH_ONE |=> phase_q == PH_TWO ##1 phase_q == PH_THREE ##1 phase_q == PH_FOUR)
		else $error("Phase sequence broken");
	inc_phase_a: assert property (!$past(count_wr) && (count_register_q != $past(count_register_q)) |-> $past(phase_q) == PH_TWO || $past(phase_q) == PH_FOUR)
		else $error("Count moved outside a sampling phase");
	unscaled_path_a: assert property (!on_timer && sample_now |=> sampled_q == $past(ext_count_input))
		else $error("Unscaled sampler did not take the pin level");
	wrap_flag_a: assert property (count_inc && !count_wr && count_register_q == COUNT_MAX |=> overflow_flag_q && count_register_q == 8'h00)
		else $error("Overflow did not wrap and set flag");
	flag_sticky_a: assert property (overflow_flag_q && !int_wr |=> overflow_flag_q)
		else $error("Overflow flag dropped without a clear");
	irq_gate_a: assert property (timer_irq |-> $past(overflow_irq_enable_q) && $past(overflow_flag_q))
		else $error("Timer request without enable");
	count_clr_a: assert property (count_wr && on_timer |=> scaler_q == 8'h00 && count_register_q == $past(reg_wdata))
		else $error("Count write did not clear scaler");
	wd_clr_a: assert property (watchdog_clear_instr && !on_timer |=> scaler_q == 8'h00 && wdt_base_q == 0)
		else $error("Watchdog clear missed scaler");
	option_load_a: assert property (reg_wr && reg_addr == REG_OPTION |=> {scaler_assign_select_q, scaler_ratio_field_q} == $past(reg_wdata[3:0]))
		else $error("Option write not taken");
	scaler_owner_a: assert property (!on_timer && !$past(on_timer) && $past(pin_if.rise) && !$past(wdt_tick) && !$past(watchdog_clear_instr) |-> $stable(scaler_q))
		else $error("Pin moved scaler while on watchdog");
	cov_overflow: cover property (count_inc && count_register_q == COUNT_MAX);
	cov_scaled_inc: cover property (on_timer && count_inc);
	cov_wdt_timeout: cover property (!on_timer && watchdog_timeout);
endmodule
`default_nettype wire

// file: design/tmx_pkg.sv
/*
 * Constants for the external-count timer with shared scaler.
 * Assumes a 25 MHz clk and a plain strobe register port.
 */
`default_nettype none
package tmx_pkg;
	localparam int ADDR_W = 3;
	localparam int DATA_W = 8;
	// Register offsets
	localparam logic [ADDR_W-1:0] REG_COUNT = 3'h0;
	localparam logic [ADDR_W-1:0] REG_OPTION = 3'h1;
	localparam logic [ADDR_W-1:0] REG_INTCTL = 3'h2;
	localparam logic [ADDR_W-1:0] REG_WDCLR = 3'h3;
	localparam logic [ADDR_W-1:0] REG_PORT = 3'h4;
	localparam logic [ADDR_W-1:0] REG_DIR = 3'h5;
	// Option fields
	localparam int OPT_RATIO_LSB = 0;
	localparam int OPT_ASSIGN_BIT = 3;
	localparam logic [3:0] OPTION_RST = 4'hf;
	// Interrupt control fields
	localparam int INT_GIE_BIT = 7;
	localparam int INT_EN_BIT = 5;
	localparam int INT_FLAG_BIT = 2;
	// Port fields
	localparam int PIN_BIT = 4;
	localparam logic PORT_LATCH_RST = 1'b0;
	localparam logic DIR_RST = 1'b1;
	localparam logic [7:0] COUNT_MAX = 8'hff;
	localparam logic [7:0] SCALER_ONE = 8'h01;
	localparam logic [7:0] TAP_BASE = 8'h02;
	localparam logic [DATA_W-1:0] READ_ZERO = 8'h00;
	// Instruction phases, Gray along the cycle
	typedef enum logic [1:0] {
		PH_ONE = 2'h0,
		PH_TWO = 2'h1,
		PH_THREE = 2'h3,
		PH_FOUR = 2'h2
	} tmx_phase_t;
endpackage
`default_nettype wire

// file: design/tmx_pin_if.sv
/*
 * Carries one raw pin level into the synchroniser and its clean level back.
 * Assumes both ends run on the same clk.
 */
`timescale 1ns/1ps
`default_nettype none
interface tmx_pin_if;
	logic raw;
	logic level;
	logic rise;
	modport src (output raw, input level, input rise);
	modport snk (input raw, output level, output rise);
endinterface
`default_nettype wire

// file: design/tmx_pin_sync.sv
/*
 * Three-stage pin synchroniser with agreement filter and rise pulse.
 * Assumes the raw input is asynchronous to clk.
 */
`timescale 1ns/1ps
`default_nettype none
module tmx_pin_sync (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Pin path
	tmx_pin_if.snk pin
);
	logic s1_q;
	logic s2_q;
	logic s3_q;
	logic level_q;
	logic rise_q;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s1_q <= 1'b0;
			s2_q <= 1'b0;
			s3_q <= 1'b0;
		end else begin
			s1_q <= pin.raw;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// Level moves only when stages two and three agree
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			level_q <= 1'b0;
			rise_q <= 1'b0;
		end else begin
			rise_q <= (s2_q == s3_q) && s3_q && !level_q;
			if (s2_q == s3_q) begin
				level_q <= s3_q;
			end
		end
	end

	assign pin.level = level_q;
	assign pin.rise = rise_q;

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	sync_agree_a: assert property (($past(s2_q) == $past(s3_q)) |-> level_q == $past(s3_q))
		else $error("Filtered pin level missed an agreed change");
	sync_hold_a: assert property (($past(s2_q) != $past(s3_q)) |-> $stable(level_q))
		else $error("Filtered pin level moved without agreement");
endmodule
`default_nettype wire

// file: verif/tmx_ext_src.sv
/*
 * Outside count source that drives the timer count pin.
 * Assumes its tasks are called just after a rising edge of clk.
 */
`timescale 1ns/1ps
`default_nettype none
module tmx_ext_src (
	// Clock
	input wire logic clk,
	// Count output
	output logic pin
);
	initial begin
		pin = 1'b0;
	end
	// Hold one level for n whole cycles
	task automatic drive(input logic v, input int n);
		pin <= v;
		repeat (n) @(posedge clk);
	endtask
	// Levels of 5 cycles cover two phases plus sync
	task automatic pulses(input int n);
		repeat (n) begin
			drive(1'b1, 5);
			drive(1'b0, 5);
		end
	endtask
endmodule
`default_nettype wire

// file: verif/testbench.sv
/*
 * Self-checking bench for the external-count timer.
 * Assumes a pull-up on the open-drain pin and a shortened watchdog base.
 */
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import tmx_pkg::*;
	logic clk, rst, reg_wr, reg_rd, src_pin;
	logic [ADDR_W-1:0] reg_addr;
	logic [DATA_W-1:0] reg_wdata, reg_rdata, rv;
	logic pin_out, pin_oe, timer_irq, watchdog_timeout;
	wire pin_in;
	int n_errors, checked, cycles;
	// Pin pulled up, device pulls it low
	assign pin_in = src_pin & ~pin_oe;
	tmx_timer #(
		.WDT_BASE_CYCLES(16)
	) u_dut (
		.clk(clk),
		.rst(rst),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_wr(reg_wr),
		.reg_rd(reg_rd),
		.reg_rdata(reg_rdata),
		.port_a_pin4_in(pin_in),
		.port_a_pin4_out(pin_out),
		.port_a_pin4_oe(pin_oe),
		.timer_irq(timer_irq),
		.watchdog_timeout(watchdog_timeout)
	);
	tmx_ext_src u_src (
		.clk(clk),
		.pin(src_pin)
	);
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles == 40000) begin
			n_errors++;
			give_verdict();
		end
	end
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("[ERR] %s expected %0h seen %0h", nm, exp, seen);
		end
	endtask
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [ADDR_W-1:0] a);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 rv = reg_rdata;
	endtask
	// Read count after the sync path has settled
	task automatic rd_count(input logic [7:0] exp);
		repeat (8) @(posedge clk);
		rd(REG_COUNT);
		chk("count", rv, exp);
	endtask
	task automatic wait_wd(output int g);
		g = 0;
		do begin
			@(negedge clk);
			g++;
		end while (watchdog_timeout !== 1'b1 && g < 600);
	endtask
	task automatic wd_gap(input int exp);
		int g;
		wait_wd(g);
		wait_wd(g);
		wait_wd(g);
		chk("wd_gap", 32'(g), 32'(exp));
	endtask
	task automatic t_reset();
		rd(REG_OPTION);
		chk("option", rv, {4'h0, OPTION_RST});
		rd(REG_COUNT);
		chk("count", rv, 8'h00);
		rd(REG_INTCTL);
		chk("intctl", rv, 8'h00);
		rd(REG_WDCLR);
		chk("wdclr", rv, 8'h00);
		rd(3'h7);
		chk("unmapped", rv, 8'h00);
		$display("done reset");
	endtask
	task automatic t_unscaled();
		wr(REG_OPTION, 8'h08);
		wr(REG_COUNT, 8'h00);
		u_src.drive(1'b1, 1);
		rd(REG_COUNT);
		chk("early", rv, 8'h00);
		u_src.drive(1'b1, 4);
		u_src.drive(1'b0, 5);
		rd_count(8'h01);
		u_src.pulses(4);
		rd_count(8'h05);
		$display("done unscaled");
	endtask
	task automatic t_ratio();
		for (int r = 0; r < 8; r++) begin
			wr(REG_OPTION, 8'(r));
			wr(REG_COUNT, 8'h00);
			u_src.pulses((3 << r) - 1);
			rd_count(8'h01);
			u_src.pulses(1);
			rd_count(8'h02);
		end
		$display("done ratio");
	endtask
	task automatic t_clear();
		wr(REG_OPTION, 8'h01);
		wr(REG_COUNT, 8'h00);
		u_src.pulses(5);
		rd_count(8'h01);
		wr(REG_COUNT, 8'h00);
		u_src.pulses(1);
		rd_count(8'h00);
		u_src.pulses(1);
		rd_count(8'h01);
		$display("done clear");
	endtask
	task automatic t_overflow();
		wr(REG_OPTION, 8'h08);
		wr(REG_INTCTL, 8'h00);
		wr(REG_COUNT, 8'hff);
		u_src.pulses(1);
		rd_count(8'h00);
		rd(REG_INTCTL);
		chk("flag", rv, 8'h04);
		chk("irq_off", timer_irq, 1'b0);
		wr(REG_INTCTL, 8'ha4);
		repeat (3) @(negedge clk);
		chk("irq_on", timer_irq, 1'b1);
		wr(REG_INTCTL, 8'ha0);
		repeat (3) @(negedge clk);
		chk("irq_clr", timer_irq, 1'b0);
		$display("done overflow");
	endtask
	task automatic t_wdog();
		int g;
		wr(REG_OPTION, 8'h00);
		wd_gap(16);
		wr(REG_OPTION, 8'h08);
		wd_gap(32);
		wr(REG_OPTION, 8'h0a);
		wd_gap(128);
		wr(REG_OPTION, 8'h08);
		wd_gap(32);
		repeat (20) @(negedge clk);
		wr(REG_WDCLR, 8'h00);
		wait_wd(g);
		chk("wd_clear", 32'(g > 24 && g < 40), 32'h1);
		$display("done watchdog");
	endtask
	task automatic t_pin();
		u_src.drive(1'b1, 6);
		rd(REG_PORT);
		chk("pin_hi", rv[PIN_BIT], 1'b1);
		wr(REG_DIR, 8'h00);
		repeat (6) @(negedge clk);
		chk("oe", pin_oe, 1'b1);
		chk("out", pin_out, 1'b0);
		rd(REG_PORT);
		chk("pin_lo", rv[PIN_BIT], 1'b0);
		wr(REG_DIR, 8'h10);
		u_src.drive(1'b0, 2);
		@(negedge clk);
		chk("oe_off", pin_oe, 1'b0);
		$display("done pin");
	endtask
	// Second reset in mid-run, with state set up that reset must undo
	task automatic t_reset_again();
		wr(REG_COUNT, 8'h5a);
		wr(REG_INTCTL, 8'ha4);
		wr(REG_DIR, 8'h00);
		repeat (2) @(negedge clk);
		chk("irq_pre", timer_irq, 1'b1);
		chk("oe_pre", pin_oe, 1'b1);
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		repeat (2) begin
			@(negedge clk);
			chk("oe_rst", pin_oe, 1'b0);
			chk("irq_rst", timer_irq, 1'b0);
			chk("wd_rst", watchdog_timeout, 1'b0);
			chk("rdata_rst", reg_rdata, 8'h00);
		end
		rd(REG_COUNT);
		chk("count_rst", rv, 8'h00);
		rd(REG_OPTION);
		chk("option_rst", rv, {4'h0, OPTION_RST});
		rd(REG_INTCTL);
		chk("intctl_rst", rv, 8'h00);
		rd(REG_DIR);
		chk("dir_rst", rv, 8'h10);
		$display("done reset again");
	endtask
	initial begin
		rst = 1'b1;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = '0;
		reg_wdata = '0;
		n_errors = 0;
		checked = 0;
		cycles = 0;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_unscaled();
		t_ratio();
		t_clear();
		t_overflow();
		t_wdog();
		t_pin();
		t_reset_again();
		give_verdict();
	end
endmodule
`default_nettype wire
